// >>> common/tmr2_pkg.sv
// Timer two package: register map, field positions, reset values, prescale constants.
// Assumes a byte-wide special-function register space reached over classic Wishbone.
package tmr2_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CONTROL = 8'hc8;
   localparam logic [7:0] OFS_MODE = 8'hc9;
   localparam logic [7:0] OFS_RELOAD_LO = 8'hca;
   localparam logic [7:0] OFS_RELOAD_HI = 8'hcb;
   localparam logic [7:0] OFS_COUNT_LO = 8'hcc;
   localparam logic [7:0] OFS_COUNT_HI = 8'hcd;
   localparam logic [7:0] OFS_CAP1_LO = 8'hce;
   localparam logic [7:0] OFS_CAP1_HI = 8'hcf;
   // Control fields
   localparam int CB_FLAG7 = 7;
   localparam int CB_EXT_FLAG = 6;
   localparam int CB_RX_BAUD = 5;
   localparam int CB_TX_BAUD = 4;
   localparam int CB_EXT_EN = 3;
   localparam int CB_RUN = 2;
   localparam int CB_SRC = 1;
   localparam int CB_CAPSEL = 0;
   // Mode fields
   localparam int MB_FASTEST = 7;
   localparam int MB_T2_RATE = 6;
   localparam int MB_T1_RATE = 5;
   localparam int MB_T0_RATE = 4;
   localparam int MB_EDGE_HI = 3;
   localparam int MB_EDGE_LO = 2;
   localparam int MB_CLK_OUT = 1;
   localparam int MB_CAP1_EN = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam logic [3:0] DIV_12 = 4'hb;
   localparam logic [3:0] DIV_4 = 4'h3;
   localparam logic [3:0] DIV_2 = 4'h1;
endpackage : tmr2_pkg

// >>> hdl/tmr2_timer.sv
// Timer two with reload, two capture channels, baud tick generation, clock output,
// and the prescaler for timers zero and one.
// Assumes count and trigger pins are synchronous to CLK; Wishbone master is classic single cycle.
// Notes on behaviour
// R1 - Sixteen-bit counter; roll-over from all ones sets overflow flag unless capture-one mode.
// R2 - Overflow flag not set while either baud select is one.
// R3 - In capture-one mode control bit seven is capture-one flag, set by count-pin edge.
// R4 - Trigger flag set on trigger-pin active edge while trigger enable is one.
// R5 - Receive baud tick from timer one when select is zero, else this timer.
// R6 - Transmit baud tick from timer one when select is zero, else this timer.
// R7 - Trigger pin ignored when enable is zero; else edge causes reload or capture unless either baud select is one.
// R8 - Counter runs only while run bit is one; software sets and clears it.
// R9 - Clock source zero counts internal clock; one counts count-pin falling edges.
// R10 - Function select zero reloads on overflow or trigger; one captures on trigger edge.
// R11 - Software keeps function select zero while either baud select is one.
// R12 - Fastest-clock bit picks undivided clock for timers on their fast clock.
// R13 - Timing use: divide by twelve, or four or one by fastest bit.
// R14 - Baud use: divide by four, or two or one by fastest bit.
// R15 - Timer one prescale: twelve, or four or one by fastest bit.
// R16 - Timer zero prescale: twelve, or four or one by fastest bit.
// R17 - Edge field: X0 falling to falling, 01 any edge, 11 rising to rising.
// R18 - Clock-output enable drives count pin at half overflow rate; else output off.
// R19 - Capture-one acts only with baud selects zero, capsel one, internal source, no output.
// R20 - Captures stored in reload/capture-two and capture-one; capture-one is read-only.
// R21 - Byte pairs also reachable as sixteen-bit word at low-byte address.
// R22 - Reload mode loads counter from reload register after each overflow.
// R23 - Pins synchronised before edge detection; one event per qualifying edge.
//
// Register access over Wishbone is this design's own decision.
module tmr2_timer #(
   parameter int DATA_W = 16
) (
   // System
   input wire logic CLK,
   input wire logic RST,
   // Wishbone slave
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [tmr2_pkg::ADDR_W-1:0] WB_ADR,
   input wire logic [1:0] WB_SEL,
   input wire logic [15:0] WB_DAT_I,
   output logic [15:0] WB_DAT_O,
   output logic WB_ACK,
   // Pins
   input wire logic COUNT_PIN_I,
   output logic COUNT_PIN_O,
   output logic COUNT_PIN_OE,
   input wire logic TRIGGER_PIN,
   // Companion timers and serial port
   input wire logic T1_OVF,
   output logic T0_TICK,
   output logic T1_TICK,
   output logic RX_BAUD_TICK,
   output logic TX_BAUD_TICK
);
   import tmr2_pkg::*;

   if (DATA_W != 16) begin : g_width_check
      $error("DATA_W must be 16");
   end

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] mode;
      logic [15:0] reload;
      logic [15:0] count;
      logic [15:0] cap1;
      logic [2:0] cnt_sync;
      logic [2:0] trg_sync;
      logic [3:0] div_tmr2;
      logic [3:0] div_t1;
      logic [3:0] div_t0;
      logic clk_out;
      logic ack;
      logic [15:0] rdat;
      logic t0_tick;
      logic t1_tick;
      logic rx_tick;
      logic tx_tick;
   } tmr2_state_t;

   tmr2_state_t s_q, s_d;

   function automatic logic [3:0] tmr2_div_limit(input logic rate, input logic fastest, input logic baud);
      if (!rate) begin
         tmr2_div_limit = baud ? DIV_4 : DIV_12;
      end else if (fastest) begin
         tmr2_div_limit = 4'h0;
      end else begin
         tmr2_div_limit = baud ? DIV_2 : DIV_4;
      end
   endfunction : tmr2_div_limit

   function automatic logic tmr2_edge(input logic [1:0] sel, input logic prev, input logic cur);
      if (!sel[0]) begin
         tmr2_edge = prev & ~cur;
      end else if (!sel[1]) begin
         tmr2_edge = prev ^ cur;
      end else begin
         tmr2_edge = ~prev & cur;
      end
   endfunction : tmr2_edge

   logic baud_mode, cap1_mode, cnt_fall, cnt_act, trg_act, tick2, inc, ovf;
   logic wr_ctl, wr_mode, wr_rl, wr_rh, wr_cl, wr_ch, bus_go;
   logic [15:0] cnt_next;

   always_comb begin
      s_d = s_q;
      baud_mode = s_q.ctl[CB_RX_BAUD] | s_q.ctl[CB_TX_BAUD];
      // Capture-one qualified by all the conditions
      cap1_mode = s_q.mode[MB_CAP1_EN] & ~baud_mode & s_q.ctl[CB_CAPSEL] & ~s_q.ctl[CB_SRC]
         & ~s_q.mode[MB_CLK_OUT]; // [R19]
      // Second stage read only by third stage and edge logic
      s_d.cnt_sync = {s_q.cnt_sync[1:0], COUNT_PIN_I}; // [R23]
      s_d.trg_sync = {s_q.trg_sync[1:0], TRIGGER_PIN}; // [R23]
      cnt_fall = s_q.cnt_sync[2] & ~s_q.cnt_sync[1]; // [R9]
      cnt_act = tmr2_edge(s_q.mode[MB_EDGE_HI:MB_EDGE_LO], s_q.cnt_sync[2], s_q.cnt_sync[1]); // [R17]
      trg_act = s_q.ctl[CB_EXT_EN]
         & tmr2_edge(s_q.mode[MB_EDGE_HI:MB_EDGE_LO], s_q.trg_sync[2], s_q.trg_sync[1]); // [R7]
      // Prescalers
      tick2 = (s_q.div_tmr2 == 4'h0);
      s_d.div_tmr2 = tick2 ? tmr2_div_limit(s_q.mode[MB_T2_RATE], s_q.mode[MB_FASTEST], baud_mode)
         : s_q.div_tmr2 - 4'h1; // [R13] [R14] [R12]
      s_d.t1_tick = (s_q.div_t1 == 4'h0);
      s_d.div_t1 = s_d.t1_tick ? tmr2_div_limit(s_q.mode[MB_T1_RATE], s_q.mode[MB_FASTEST], 1'b0)
         : s_q.div_t1 - 4'h1; // [R15]
      s_d.t0_tick = (s_q.div_t0 == 4'h0);
      s_d.div_t0 = s_d.t0_tick ? tmr2_div_limit(s_q.mode[MB_T0_RATE], s_q.mode[MB_FASTEST], 1'b0)
         : s_q.div_t0 - 4'h1; // [R16]
      inc = s_q.ctl[CB_RUN] & (s_q.ctl[CB_SRC] ? cnt_fall : tick2); // [R8] [R9]
      ovf = inc & (s_q.count == ALL_ONES); // [R1]
      cnt_next = inc ? s_q.count + 16'h0001 : s_q.count;
      // Reload on overflow in reload or baud mode, or on trigger in reload mode
      if ((ovf && (!s_q.ctl[CB_CAPSEL] || baud_mode)) || (trg_act && !s_q.ctl[CB_CAPSEL] && !baud_mode)) begin
         cnt_next = s_q.reload; // [R22] [R10]
      end
      s_d.rx_tick = s_q.ctl[CB_RX_BAUD] ? ovf : T1_OVF; // [R5]
      s_d.tx_tick = s_q.ctl[CB_TX_BAUD] ? ovf : T1_OVF; // [R6]
      if (ovf && s_q.mode[MB_CLK_OUT]) begin
         s_d.clk_out = ~s_q.clk_out; // [R18]
      end
      if (!s_q.mode[MB_CLK_OUT]) begin
         s_d.clk_out = 1'b0; // [R18]
      end
      // Bus decode
      bus_go = WB_CYC & WB_STB & ~s_q.ack;
      wr_ctl = bus_go & WB_WE & WB_SEL[0] & (WB_ADR == OFS_CONTROL);
      wr_mode = bus_go & WB_WE & WB_SEL[0] & (WB_ADR == OFS_MODE);
      wr_rl = bus_go & WB_WE & WB_SEL[0] & (WB_ADR == OFS_RELOAD_LO);
      wr_rh = bus_go & WB_WE & ((WB_SEL[0] & (WB_ADR == OFS_RELOAD_HI))
         | (WB_SEL[1] & (WB_ADR == OFS_RELOAD_LO))); // [R21]
      wr_cl = bus_go & WB_WE & WB_SEL[0] & (WB_ADR == OFS_COUNT_LO);
      wr_ch = bus_go & WB_WE & ((WB_SEL[0] & (WB_ADR == OFS_COUNT_HI))
         | (WB_SEL[1] & (WB_ADR == OFS_COUNT_LO))); // [R21]
      s_d.ack = bus_go;
      s_d.rdat = 16'h0000;
      if (bus_go && !WB_WE) begin
         case (WB_ADR)
            OFS_CONTROL: s_d.rdat = {8'h00, s_q.ctl};
            OFS_MODE: s_d.rdat = {8'h00, s_q.mode};
            OFS_RELOAD_LO: s_d.rdat = s_q.reload; // [R21]
            OFS_RELOAD_HI: s_d.rdat = {8'h00, s_q.reload[15:8]};
            OFS_COUNT_LO: s_d.rdat = s_q.count; // [R21]
            OFS_COUNT_HI: s_d.rdat = {8'h00, s_q.count[15:8]};
            OFS_CAP1_LO: s_d.rdat = s_q.cap1;
            OFS_CAP1_HI: s_d.rdat = {8'h00, s_q.cap1[15:8]};
            default: s_d.rdat = 16'h0000;
         endcase
      end
      // Software writes first, except count writes, which follow and beat the counter update; hardware events then win over clears
      if (wr_ctl) s_d.ctl = WB_DAT_I[7:0]; // [R8]
      if (wr_mode) s_d.mode = WB_DAT_I[7:0];
      if (wr_rl) s_d.reload[7:0] = WB_DAT_I[7:0];
      if (wr_rh) s_d.reload[15:8] = (WB_ADR == OFS_RELOAD_LO) ? WB_DAT_I[15:8] : WB_DAT_I[7:0];
      s_d.count = cnt_next;
      if (wr_cl) s_d.count[7:0] = WB_DAT_I[7:0];
      if (wr_ch) s_d.count[15:8] = (WB_ADR == OFS_COUNT_LO) ? WB_DAT_I[15:8] : WB_DAT_I[7:0];
      if (ovf && !cap1_mode && !baud_mode) s_d.ctl[CB_FLAG7] = 1'b1; // [R1] [R2]
      if (cap1_mode && cnt_act) begin
         s_d.ctl[CB_FLAG7] = 1'b1; // [R3]
         s_d.cap1 = s_q.count; // [R20]
      end
      if (trg_act) begin
         s_d.ctl[CB_EXT_FLAG] = 1'b1; // [R4]
         if (s_q.ctl[CB_CAPSEL] && !baud_mode) s_d.reload = s_q.count; // [R10] [R20]
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s_q <= '0;
         s_q.ctl <= RST_BYTE;
         s_q.mode <= RST_BYTE;
         s_q.reload <= RST_WORD;
         s_q.count <= RST_WORD;
      end else begin
         s_q <= s_d;
      end
   end

   assign WB_DAT_O = s_q.rdat;
   assign WB_ACK = s_q.ack;
   assign COUNT_PIN_O = s_q.clk_out;
   assign COUNT_PIN_OE = s_q.mode[MB_CLK_OUT]; // [R18]
   assign T0_TICK = s_q.t0_tick;
   assign T1_TICK = s_q.t1_tick;
   assign RX_BAUD_TICK = s_q.rx_tick;
   assign TX_BAUD_TICK = s_q.tx_tick;

   AST_OVF_FLAG: assert property (@(posedge CLK) disable iff (RST) // [R1]
      ovf && !cap1_mode && !baud_mode |=> s_q.ctl[CB_FLAG7])
      else $error("overflow flag not set");

   AST_FLAG_STICKY: assert property (@(posedge CLK) disable iff (RST) // [R1]
      s_q.ctl[CB_FLAG7] && !wr_ctl |=> s_q.ctl[CB_FLAG7])
      else $error("flag seven cleared by hardware");

   AST_ROLL_ZERO: assert property (@(posedge CLK) disable iff (RST) // [R1]
      ovf && s_q.ctl[CB_CAPSEL] && !baud_mode && !wr_cl && !wr_ch |=> s_q.count == RST_WORD)
      else $error("counter did not roll to zero");

   AST_BAUD_NO_FLAG: assert property (@(posedge CLK) disable iff (RST) // [R2]
      baud_mode && !wr_ctl && !s_q.ctl[CB_FLAG7] && !cap1_mode |=> !s_q.ctl[CB_FLAG7])
      else $error("flag set in baud mode");

   AST_CAP1: assert property (@(posedge CLK) disable iff (RST) // [R3]
      cap1_mode && cnt_act |=> s_q.cap1 == $past(s_q.count) && s_q.ctl[CB_FLAG7])
      else $error("capture one missed");

   AST_CAP1_NO_OVF_FLAG: assert property (@(posedge CLK) disable iff (RST) // [R3]
      cap1_mode && !cnt_act && !wr_ctl && !s_q.ctl[CB_FLAG7] |=> !s_q.ctl[CB_FLAG7])
      else $error("capture one flag set without edge");

   AST_TRG_FLAG: assert property (@(posedge CLK) disable iff (RST) // [R4]
      trg_act |=> s_q.ctl[CB_EXT_FLAG])
      else $error("trigger flag not set");

   AST_EXT_STICKY: assert property (@(posedge CLK) disable iff (RST) // [R4]
      s_q.ctl[CB_EXT_FLAG] && !wr_ctl |=> s_q.ctl[CB_EXT_FLAG])
      else $error("trigger flag cleared by hardware");

   AST_RX_SEL: assert property (@(posedge CLK) disable iff (RST) // [R5]
      !s_q.ctl[CB_RX_BAUD] |=> RX_BAUD_TICK == $past(T1_OVF))
      else $error("rx tick wrong");

   AST_TX_SEL: assert property (@(posedge CLK) disable iff (RST) // [R6]
      !s_q.ctl[CB_TX_BAUD] |=> TX_BAUD_TICK == $past(T1_OVF))
      else $error("tx tick wrong");

   AST_RX_OWN: assert property (@(posedge CLK) disable iff (RST) // [R5]
      s_q.ctl[CB_RX_BAUD] |=> RX_BAUD_TICK == $past(ovf))
      else $error("rx tick not from own overflow");

   AST_TX_OWN: assert property (@(posedge CLK) disable iff (RST) // [R6]
      s_q.ctl[CB_TX_BAUD] |=> TX_BAUD_TICK == $past(ovf))
      else $error("tx tick not from own overflow");

   AST_TRG_IGNORED: assert property (@(posedge CLK) disable iff (RST) // [R7]
      !s_q.ctl[CB_EXT_EN] && !wr_ctl && !s_q.ctl[CB_EXT_FLAG] |=> !s_q.ctl[CB_EXT_FLAG])
      else $error("trigger seen while disabled");

   AST_STOPPED: assert property (@(posedge CLK) disable iff (RST) // [R8]
      !s_q.ctl[CB_RUN] && !wr_cl && !wr_ch && !trg_act |=> $stable(s_q.count))
      else $error("counter moved while stopped");

   AST_RUN_HOLD: assert property (@(posedge CLK) disable iff (RST) // [R8]
      !wr_ctl |=> s_q.ctl[CB_RUN] == $past(s_q.ctl[CB_RUN]))
      else $error("run bit changed by hardware");

   AST_RUN_COUNT: assert property (@(posedge CLK) disable iff (RST) // [R8] [R13]
      s_q.ctl[CB_RUN] && !s_q.ctl[CB_SRC] && tick2 && !ovf && !trg_act && !wr_cl && !wr_ch
      |=> s_q.count == $past(s_q.count) + 16'h0001)
      else $error("internal count step missed");

   AST_PIN_COUNT: assert property (@(posedge CLK) disable iff (RST) // [R9]
      s_q.ctl[CB_RUN] && s_q.ctl[CB_SRC] && cnt_fall && !ovf && !trg_act && !wr_cl && !wr_ch
      |=> s_q.count == $past(s_q.count) + 16'h0001)
      else $error("pin count step missed");

   AST_PIN_IDLE: assert property (@(posedge CLK) disable iff (RST) // [R9]
      s_q.ctl[CB_RUN] && s_q.ctl[CB_SRC] && !cnt_fall && !trg_act && !wr_cl && !wr_ch |=> $stable(s_q.count))
      else $error("pin counter moved without edge");

   AST_CAPTURE_TWO: assert property (@(posedge CLK) disable iff (RST) // [R10] [R20]
      trg_act && s_q.ctl[CB_CAPSEL] && !baud_mode |=> s_q.reload == $past(s_q.count))
      else $error("capture two missed");

   AST_TRG_RELOAD: assert property (@(posedge CLK) disable iff (RST) // [R10]
      trg_act && !s_q.ctl[CB_CAPSEL] && !baud_mode && !wr_cl && !wr_ch |=> s_q.count == $past(s_q.reload))
      else $error("trigger reload missed");

   AST_RELOAD: assert property (@(posedge CLK) disable iff (RST) // [R22]
      ovf && !s_q.ctl[CB_CAPSEL] && !wr_cl && !wr_ch |=> s_q.count == $past(s_q.reload))
      else $error("reload missed");

   AST_BAUD_RELOAD: assert property (@(posedge CLK) disable iff (RST) // [R22]
      ovf && baud_mode && !wr_cl && !wr_ch |=> s_q.count == $past(s_q.reload))
      else $error("baud reload missed");

   AST_DIV_STD: assert property (@(posedge CLK) disable iff (RST) // [R13]
      tick2 && !s_q.mode[MB_T2_RATE] && !baud_mode |=> s_q.div_tmr2 == DIV_12)
      else $error("standard timing divide wrong");

   AST_DIV_FAST: assert property (@(posedge CLK) disable iff (RST) // [R13]
      tick2 && s_q.mode[MB_T2_RATE] && !s_q.mode[MB_FASTEST] && !baud_mode |=> s_q.div_tmr2 == DIV_4)
      else $error("fast timing divide wrong");

   AST_DIV_BAUD_STD: assert property (@(posedge CLK) disable iff (RST) // [R14]
      tick2 && !s_q.mode[MB_T2_RATE] && baud_mode |=> s_q.div_tmr2 == DIV_4)
      else $error("standard baud divide wrong");

   AST_DIV_BAUD_FAST: assert property (@(posedge CLK) disable iff (RST) // [R14]
      tick2 && s_q.mode[MB_T2_RATE] && !s_q.mode[MB_FASTEST] && baud_mode |=> s_q.div_tmr2 == DIV_2)
      else $error("fast baud divide wrong");

   AST_DIV_FASTEST: assert property (@(posedge CLK) disable iff (RST) // [R12]
      tick2 && s_q.mode[MB_T2_RATE] && s_q.mode[MB_FASTEST] |=> s_q.div_tmr2 == 4'h0)
      else $error("fastest clock divided");

   AST_DIV_COUNTDOWN: assert property (@(posedge CLK) disable iff (RST) // [R13]
      !tick2 |=> s_q.div_tmr2 == $past(s_q.div_tmr2) - 4'h1)
      else $error("prescaler skipped a step");

   AST_T1_STD: assert property (@(posedge CLK) disable iff (RST) // [R15]
      s_q.div_t1 == 4'h0 && !s_q.mode[MB_T1_RATE] |=> s_q.div_t1 == DIV_12 && T1_TICK)
      else $error("timer one standard prescale wrong");

   AST_T1_FAST: assert property (@(posedge CLK) disable iff (RST) // [R15]
      s_q.div_t1 == 4'h0 && s_q.mode[MB_T1_RATE] && !s_q.mode[MB_FASTEST] |=> s_q.div_t1 == DIV_4 && T1_TICK)
      else $error("timer one fast prescale wrong");

   AST_T0_STD: assert property (@(posedge CLK) disable iff (RST) // [R16]
      s_q.div_t0 == 4'h0 && !s_q.mode[MB_T0_RATE] |=> s_q.div_t0 == DIV_12 && T0_TICK)
      else $error("timer zero standard prescale wrong");

   AST_T0_FAST: assert property (@(posedge CLK) disable iff (RST) // [R16]
      s_q.div_t0 == 4'h0 && s_q.mode[MB_T0_RATE] && !s_q.mode[MB_FASTEST] |=> s_q.div_t0 == DIV_4 && T0_TICK)
      else $error("timer zero fast prescale wrong");

   AST_T0_FASTEST: assert property (@(posedge CLK) disable iff (RST) // [R12]
      s_q.div_t0 == 4'h0 && s_q.mode[MB_T0_RATE] && s_q.mode[MB_FASTEST] |=> s_q.div_t0 == 4'h0 && T0_TICK)
      else $error("timer zero fastest prescale wrong");

   AST_EDGE_FALL: assert property (@(posedge CLK) disable iff (RST) // [R17]
      cap1_mode && !s_q.mode[MB_EDGE_LO] && s_q.cnt_sync[2] && !s_q.cnt_sync[1] |=> s_q.ctl[CB_FLAG7])
      else $error("falling edge not captured");

   AST_EDGE_ANY: assert property (@(posedge CLK) disable iff (RST) // [R17]
      cap1_mode && !s_q.mode[MB_EDGE_HI] && s_q.mode[MB_EDGE_LO] && (s_q.cnt_sync[2] != s_q.cnt_sync[1])
      |=> s_q.ctl[CB_FLAG7])
      else $error("level change not captured");

   AST_EDGE_RISE: assert property (@(posedge CLK) disable iff (RST) // [R17]
      cap1_mode && s_q.mode[MB_EDGE_HI] && s_q.mode[MB_EDGE_LO] && !s_q.cnt_sync[2] && s_q.cnt_sync[1]
      |=> s_q.ctl[CB_FLAG7])
      else $error("rising edge not captured");

   AST_EDGE_RISE_ONLY: assert property (@(posedge CLK) disable iff (RST) // [R17]
      cap1_mode && s_q.mode[MB_EDGE_HI] && s_q.mode[MB_EDGE_LO] && s_q.cnt_sync[2] && !s_q.cnt_sync[1]
      && !wr_ctl && !s_q.ctl[CB_FLAG7] |=> !s_q.ctl[CB_FLAG7])
      else $error("falling edge captured in rising mode");

   AST_CLKOUT_TOGGLE: assert property (@(posedge CLK) disable iff (RST) // [R18]
      ovf && s_q.mode[MB_CLK_OUT] |=> COUNT_PIN_O != $past(COUNT_PIN_O))
      else $error("clock output did not toggle");

   AST_CLKOUT_OFF: assert property (@(posedge CLK) disable iff (RST) // [R18]
      !s_q.mode[MB_CLK_OUT] |=> !COUNT_PIN_O)
      else $error("clock output active while off");

   AST_OE_FOLLOWS: assert property (@(posedge CLK) disable iff (RST) // [R18]
      wr_mode |=> COUNT_PIN_OE == $past(WB_DAT_I[MB_CLK_OUT]))
      else $error("pin enable does not follow mode");

   AST_CAP1_GATED: assert property (@(posedge CLK) disable iff (RST) // [R19] [R20]
      !cap1_mode |=> $stable(s_q.cap1))
      else $error("capture one changed outside its mode");

   AST_WORD_READ: assert property (@(posedge CLK) disable iff (RST) // [R21]
      bus_go && !WB_WE && WB_ADR == OFS_COUNT_LO |=> WB_DAT_O == $past(s_q.count))
      else $error("counter word read wrong");

   AST_WORD_WRITE: assert property (@(posedge CLK) disable iff (RST) // [R21]
      bus_go && WB_WE && WB_SEL == 2'b11 && WB_ADR == OFS_RELOAD_LO && !trg_act |=> s_q.reload == $past(WB_DAT_I))
      else $error("reload word write wrong");

   AST_CNT_WORD_WRITE: assert property (@(posedge CLK) disable iff (RST) // [R21]
      bus_go && WB_WE && WB_SEL == 2'b11 && WB_ADR == OFS_COUNT_LO |=> s_q.count == $past(WB_DAT_I))
      else $error("counter word write wrong");

   AST_ACK_ANSWER: assert property (@(posedge CLK) disable iff (RST)
      bus_go |=> WB_ACK)
      else $error("request not acknowledged");
endmodule : tmr2_timer

// >>> tb/tmr2_timer_tb.sv
// Self-checking bench for timer two: register map, counting, flags, baud ticks.
// Assumes the design package is compiled first; drives all ports itself.
module tmr2_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tmr2_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cnt_i = 1'b1, cnt_o, cnt_oe;
   logic trig = 1'b1, t1_ovf = 1'b0, t0_tick, t1_tick, rx_tick, tx_tick;
   logic [7:0] adr = 8'h00;
   logic [1:0] sel = 2'b00;
   logic [15:0] dat_i = 16'h0000, dat_o, rd;
   int miscompares = 0, comparisons = 0, seed = 32'h79f8;
   int model[int];
   tmr2_timer DUT (.CLK(clk), .RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
      .WB_SEL(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK(ack), .COUNT_PIN_I(cnt_i),
      .COUNT_PIN_O(cnt_o), .COUNT_PIN_OE(cnt_oe), .TRIGGER_PIN(trig), .T1_OVF(t1_ovf),
      .T0_TICK(t0_tick), .T1_TICK(t1_tick), .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick));
   initial begin
      forever #25 clk = ~clk;
   end
   task check(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // Clock cycles from the end of one prescale pulse to the next
   task gap(input int which, output int g);
      g = 0;
      if (which) @(negedge t1_tick);
      else @(negedge t0_tick);
      do begin
         @(negedge clk);
         g++;
      end while ((which ? t1_tick : t0_tick) !== 1'b1);
      @(posedge clk);
   endtask : gap
   // Classic single cycle; entered just after a rising edge
   task wb(input logic w, input logic [7:0] a, input logic [1:0] s, input logic [15:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_i <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask : wb
   // Model keeps software-visible bytes of the plain storage registers
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
      wb(1'b1, a, s, d);
      if (a >= OFS_CONTROL && a <= OFS_COUNT_HI) begin
         if (s[0]) model[a] = d[7:0];
         if (s[1]) model[a + 1] = d[15:8];
      end
   endtask : wr
   task rdchk(input string name, input logic [7:0] a, input logic [1:0] s);
      logic [15:0] e;
      e = 16'h0000;
      if (model.exists(a) && s[0]) e[7:0] = model[a];
      if (model.exists(a + 1) && s[1]) e[15:8] = model[a + 1];
      wb(1'b0, a, s, 16'h0000);
      check(name, e, rd);
   endtask : rdchk
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test();
   end
   initial begin
      logic [15:0] r;
      int n, g;
      for (int a = 'hc8; a <= 'hcf; a++) model[a] = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 'hc8; a <= 'hcf; a++) rdchk("reset byte", a[7:0], 2'b01);
      rdchk("unmapped", 8'h10, 2'b11);
      r = $random(seed);
      wr(OFS_RELOAD_LO, r, 2'b11);
      rdchk("reload word", OFS_RELOAD_LO, 2'b11);
      rdchk("reload high", OFS_RELOAD_HI, 2'b01);
      wb(1'b1, OFS_CAP1_LO, 2'b11, 16'hffff);
      rdchk("cap1 read only", OFS_CAP1_LO, 2'b11);
      // Undivided clock, reload near all ones, clock output on
      wr(OFS_MODE, 16'h00c2, 2'b01);
      check("pin enable", 1'b1, cnt_oe);
      // Let the prescaler settle on the undivided rate
      repeat (12) @(posedge clk);
      wr(OFS_RELOAD_LO, 16'hfff0, 2'b11);
      wr(OFS_COUNT_LO, 16'hfff0, 2'b11);
      wr(OFS_CONTROL, 16'h0004, 2'b01);
      repeat (12) @(posedge clk);
      wb(1'b0, OFS_CONTROL, 2'b01, 16'h0000);
      check("no early flag", 16'h0004, rd);
      check("clock out", 1'b1, cnt_o);
      repeat (20) @(posedge clk);
      wb(1'b0, OFS_CONTROL, 2'b01, 16'h0000);
      check("overflow flag", 16'h0084, rd);
      wb(1'b0, OFS_COUNT_LO, 2'b11, 16'h0000);
      check("reloaded range", 1'b1, rd >= 16'hfff0);
      wr(OFS_CONTROL, 16'h0000, 2'b01);
      wb(1'b0, OFS_COUNT_LO, 2'b11, 16'h0000);
      r = rd;
      repeat (10) @(posedge clk);
      wb(1'b0, OFS_COUNT_LO, 2'b11, 16'h0000);
      check("stopped counter", r, rd);
      rdchk("flag cleared", OFS_CONTROL, 2'b01);
      wr(OFS_MODE, 16'h00c0, 2'b01);
      check("pin released", 1'b0, cnt_oe);
      // Baud selects on: counting must not raise the flag
      wr(OFS_CONTROL, 16'h0034, 2'b01);
      repeat (40) @(posedge clk);
      rdchk("flag blocked", OFS_CONTROL, 2'b01);
      wr(OFS_CONTROL, 16'h0000, 2'b01);
      t1_ovf <= 1'b1;
      @(posedge clk);
      t1_ovf <= 1'b0;
      @(negedge clk);
      check("rx tick", 1'b1, rx_tick);
      check("tx tick", 1'b1, tx_tick);
      @(posedge clk);
      // Trigger falling edge: ignored, then flagged
      for (int en = 0; en < 2; en++) begin
         wr(OFS_CONTROL, en ? 16'h0008 : 16'h0000, 2'b01);
         trig <= 1'b0;
         repeat (8) @(posedge clk);
         trig <= 1'b1;
         repeat (8) @(posedge clk);
         wb(1'b0, OFS_CONTROL, 2'b01, 16'h0000);
         check("trigger flag", en ? 16'h0048 : 16'h0000, rd);
      end
      // Trigger edge captures a stopped counter into the reload register
      r = $random(seed);
      wr(OFS_COUNT_LO, r, 2'b11);
      wr(OFS_CONTROL, 16'h0009, 2'b01);
      trig <= 1'b0;
      repeat (8) @(posedge clk);
      trig <= 1'b1;
      repeat (8) @(posedge clk);
      model[OFS_RELOAD_LO] = r[7:0];
      model[OFS_RELOAD_HI] = r[15:8];
      rdchk("capture two", OFS_RELOAD_LO, 2'b11);
      // Count pin falling edges
      wr(OFS_COUNT_LO, 16'h0000, 2'b11);
      wr(OFS_CONTROL, 16'h0006, 2'b01);
      n = 1 + ($random(seed) & 7);
      repeat (n) begin
         cnt_i <= 1'b0;
         repeat (4) @(posedge clk);
         cnt_i <= 1'b1;
         repeat (4) @(posedge clk);
      end
      wb(1'b0, OFS_COUNT_LO, 2'b11, 16'h0000);
      check("pin count", n[15:0], rd);
      wr(OFS_CONTROL, 16'h0000, 2'b01);
      // Capture one on a count-pin falling edge
      r = $random(seed);
      wr(OFS_COUNT_LO, r, 2'b11);
      wr(OFS_MODE, 16'h0001, 2'b01);
      wr(OFS_CONTROL, 16'h0001, 2'b01);
      cnt_i <= 1'b0;
      repeat (8) @(posedge clk);
      cnt_i <= 1'b1;
      repeat (8) @(posedge clk);
      wb(1'b0, OFS_CAP1_LO, 2'b11, 16'h0000);
      check("capture one", r, rd);
      wb(1'b0, OFS_CONTROL, 2'b01, 16'h0000);
      check("capture one flag", 16'h0081, rd);
      // Prescale pulses for the companion timers
      gap(1, g);
      check("timer one period", 16'h000c, g[15:0]);
      wr(OFS_MODE, 16'h0010, 2'b01);
      gap(0, g);
      check("timer zero period", 16'h0004, g[15:0]);
      stop_test();
   end
endmodule : tmr2_timer_tb
